// ---- verilog/sbcp_defines.svh ----
// offsets, field positions, reset values and limits of the config words
`ifndef SBCP_DEFINES_SVH
`define SBCP_DEFINES_SVH

`define SBCP_ADDR_PULSE_REF   16'h0200
`define SBCP_ADDR_MODE_DIR    16'h0202
`define SBCP_ADDR_LIMIT_EN    16'h0204

`define SBCP_RST_PULSE_REF    16'h0002
`define SBCP_RST_MODE_DIR     16'h0000
`define SBCP_RST_LIMIT_EN     16'h0000

`define SBCP_MAX_PULSE_REF    16'h1132
`define SBCP_MAX_MODE_DIR     16'h110a
`define SBCP_MAX_LIMIT_EN     16'h0011

`define SBCP_MODE_FIELD_LSB   0
`define SBCP_DIR_FIELD_LSB    8
`define SBCP_REMAP_FIELD_LSB  12
`define SBCP_VLIM_FIELD_LSB   0
`define SBCP_TLIM_FIELD_LSB   4

`define SBCP_IN_VLIM          0
`define SBCP_IN_TLIM          1
`define SBCP_IN_VSEL0         2
`define SBCP_IN_VSEL1         3
`define SBCP_IN_TSEL0         4
`define SBCP_IN_TSEL1         5
`define SBCP_IN_COUNT         6

`endif

// ---- verilog/sbcp_pkg.sv ----
// types shared by the servo basic config block
`default_nettype none
package sbcp_pkg;
    typedef logic [15:0] sbcp_word_type;
    typedef enum logic [2:0] {
        SBCP_RESP_OK       = 3'b001,
        SBCP_RESP_REFUSED  = 3'b010,
        SBCP_RESP_UNMAPPED = 3'b100
    } sbcp_resp_type;
endpackage
`default_nettype wire

// ---- verilog/sbcp_value_select.sv ----
// picks one of three stored values, or the external value, by a 2-bit code
`default_nettype none
module sbcp_value_select #(
    parameter int WIDTH = 16
) (
    input  wire logic [1:0]       code_in,
    input  wire logic [WIDTH-1:0] ext_value_in,
    input  wire logic [WIDTH-1:0] value1_in,
    input  wire logic [WIDTH-1:0] value2_in,
    input  wire logic [WIDTH-1:0] value3_in,
    output logic      [WIDTH-1:0] selected_out
);
    // code 0 leaves the reference to the external (analog) source
    always_comb begin
        unique case (code_in)
            2'h1:    selected_out = value1_in;
            2'h2:    selected_out = value2_in;
            2'h3:    selected_out = value3_in;
            default: selected_out = ext_value_in;
        endcase
    end
endmodule
`default_nettype wire

// ---- verilog/sbcp_config_regs.sv ----
// basic configuration words of the servo drive with limit selection
`default_nettype none
`include "sbcp_defines.svh"
module sbcp_config_regs (
    input  wire logic        mclk_in,
    input  wire logic        reset_in,
    input  wire logic [15:0] reg_addr_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [15:0] reg_wdata_in,
    output logic      [15:0] reg_rdata_out,
    output logic      [2:0]  reg_resp_out,
    output logic             reg_done_out,
    input  wire logic        power_stage_enabled_in,
    input  wire logic        power_on_event_in,
    input  wire logic        velocity_limit_input_in,
    input  wire logic        torque_limit_input_in,
    input  wire logic        velocity_select_bit0_in,
    input  wire logic        velocity_select_bit1_in,
    input  wire logic        torque_select_bit0_in,
    input  wire logic        torque_select_bit1_in,
    input  wire logic [31:0] velocity_value1_in,
    input  wire logic [31:0] velocity_value2_in,
    input  wire logic [31:0] velocity_value3_in,
    input  wire logic [31:0] velocity_analog_in,
    input  wire logic [15:0] torque_value1_in,
    input  wire logic [15:0] torque_value2_in,
    input  wire logic [15:0] torque_value3_in,
    input  wire logic [15:0] torque_analog_in,
    input  wire logic [15:0] torque_actual_in,
    output logic      [15:0] pulse_reference_out,
    output logic      [3:0]  operating_mode_out,
    output logic      [3:0]  direction_out,
    output logic             io_preset_load_out,
    output logic             velocity_limit_active_out,
    output logic             torque_limit_active_out,
    output logic      [31:0] velocity_reference_out,
    output logic      [15:0] torque_reference_out,
    output logic             torque_limit_reached_out
);
    sbcp_pkg::sbcp_word_type pulse_reference_config_r;
    sbcp_pkg::sbcp_word_type mode_direction_config_r;
    sbcp_pkg::sbcp_word_type limit_enable_config_r;
    sbcp_pkg::sbcp_word_type mode_active_r;
    logic [`SBCP_IN_COUNT-1:0] in_meta_r;
    logic [`SBCP_IN_COUNT-1:0] in_sync_r;
    logic [31:0]               vel_sel;
    logic [15:0]               trq_sel;
    logic                      wr_pulse_ok;
    logic                      wr_mode_ok;
    logic                      wr_limit_ok;
    logic                      addr_hit;

    // every nibble must stay at or below the matching nibble of the maximum
    function automatic logic digits_ok(input logic [15:0] value,
                                       input logic [15:0] max);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (value[i*4 +: 4] > max[i*4 +: 4]) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    function automatic logic [15:0] magnitude16(input logic [15:0] value);
        return value[15] ? 16'(-value) : value;
    endfunction

    assign addr_hit = (reg_addr_in == `SBCP_ADDR_PULSE_REF)
                   || (reg_addr_in == `SBCP_ADDR_MODE_DIR)
                   || (reg_addr_in == `SBCP_ADDR_LIMIT_EN);

    // the power stage flag comes from on-chip logic on this clock
    assign wr_pulse_ok = reg_wr_in
        && (reg_addr_in == `SBCP_ADDR_PULSE_REF)
        && !power_stage_enabled_in
        && digits_ok(reg_wdata_in, `SBCP_MAX_PULSE_REF);
    assign wr_mode_ok = reg_wr_in
        && (reg_addr_in == `SBCP_ADDR_MODE_DIR)
        && digits_ok(reg_wdata_in, `SBCP_MAX_MODE_DIR);
    assign wr_limit_ok = reg_wr_in
        && (reg_addr_in == `SBCP_ADDR_LIMIT_EN)
        && digits_ok(reg_wdata_in, `SBCP_MAX_LIMIT_EN);

    // input functions arrive from pins
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            in_meta_r <= '0;
            in_sync_r <= '0;
        end else begin
            in_meta_r <= {torque_select_bit1_in, torque_select_bit0_in,
                          velocity_select_bit1_in, velocity_select_bit0_in,
                          torque_limit_input_in, velocity_limit_input_in};
            in_sync_r <= in_meta_r;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            pulse_reference_config_r <= `SBCP_RST_PULSE_REF;
        end else if (wr_pulse_ok) begin
            pulse_reference_config_r <= reg_wdata_in;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            mode_direction_config_r <= `SBCP_RST_MODE_DIR;
        end else if (wr_mode_ok) begin
            mode_direction_config_r <= reg_wdata_in;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            limit_enable_config_r <= `SBCP_RST_LIMIT_EN;
        end else if (wr_limit_ok) begin
            limit_enable_config_r <= reg_wdata_in;
        end
    end

    // stored mode only takes over at the power-on event, never on a write
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            mode_active_r <= `SBCP_RST_MODE_DIR;
        end else if (power_on_event_in) begin
            mode_active_r <= mode_direction_config_r;
        end
    end

    // preset reload only when the mode actually changes and remap is set
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            io_preset_load_out <= 1'b0;
        end else begin
            io_preset_load_out <= power_on_event_in
                && mode_direction_config_r[`SBCP_REMAP_FIELD_LSB]
                && (mode_direction_config_r[`SBCP_MODE_FIELD_LSB +: 4]
                    != mode_active_r[`SBCP_MODE_FIELD_LSB +: 4]);
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            operating_mode_out  <= 4'h0;
            direction_out       <= 4'h0;
            pulse_reference_out <= `SBCP_RST_PULSE_REF;
        end else begin
            operating_mode_out  <= mode_active_r[`SBCP_MODE_FIELD_LSB +: 4];
            direction_out       <= mode_active_r[`SBCP_DIR_FIELD_LSB +: 4];
            pulse_reference_out <= pulse_reference_config_r;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            velocity_limit_active_out <= 1'b0;
            torque_limit_active_out   <= 1'b0;
        end else begin
            velocity_limit_active_out <=
                limit_enable_config_r[`SBCP_VLIM_FIELD_LSB]
                || in_sync_r[`SBCP_IN_VLIM];
            torque_limit_active_out <=
                limit_enable_config_r[`SBCP_TLIM_FIELD_LSB]
                || in_sync_r[`SBCP_IN_TLIM];
        end
    end

    sbcp_value_select #(
        .WIDTH (32)
    ) u_vel_select (
        .code_in      ({in_sync_r[`SBCP_IN_VSEL1],
                        in_sync_r[`SBCP_IN_VSEL0]}),
        .ext_value_in (velocity_analog_in),
        .value1_in    (velocity_value1_in),
        .value2_in    (velocity_value2_in),
        .value3_in    (velocity_value3_in),
        .selected_out (vel_sel)
    );

    sbcp_value_select #(
        .WIDTH (16)
    ) u_trq_select (
        .code_in      ({in_sync_r[`SBCP_IN_TSEL1],
                        in_sync_r[`SBCP_IN_TSEL0]}),
        .ext_value_in (torque_analog_in),
        .value1_in    (torque_value1_in),
        .value2_in    (torque_value2_in),
        .value3_in    (torque_value3_in),
        .selected_out (trq_sel)
    );

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            velocity_reference_out <= 32'h0000_0000;
            torque_reference_out   <= 16'h0000;
        end else begin
            velocity_reference_out <= vel_sel;
            torque_reference_out   <= trq_sel;
        end
    end

    // compared on magnitude so negative limits work in either direction
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            torque_limit_reached_out <= 1'b0;
        end else begin
            torque_limit_reached_out <=
                magnitude16(torque_actual_in) >= magnitude16(trq_sel);
        end
    end

    // one answer per request; writes win over reads in the same cycle
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            reg_done_out <= 1'b0;
            reg_resp_out <= sbcp_pkg::SBCP_RESP_OK;
        end else begin
            reg_done_out <= reg_wr_in || reg_rd_in;
            if (!addr_hit) begin
                reg_resp_out <= sbcp_pkg::SBCP_RESP_UNMAPPED;
            end else if (reg_wr_in && !(wr_pulse_ok || wr_mode_ok
                                        || wr_limit_ok)) begin
                reg_resp_out <= sbcp_pkg::SBCP_RESP_REFUSED;
            end else begin
                reg_resp_out <= sbcp_pkg::SBCP_RESP_OK;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (reg_rd_in && !reg_wr_in) begin
            unique case (reg_addr_in)
                `SBCP_ADDR_PULSE_REF:
                    reg_rdata_out <= pulse_reference_config_r;
                `SBCP_ADDR_MODE_DIR:  reg_rdata_out <= mode_direction_config_r;
                `SBCP_ADDR_LIMIT_EN:  reg_rdata_out <= limit_enable_config_r;
                default:              reg_rdata_out <= 16'h0000;
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- sim/sbcp_config_regs_chk.sv ----
// concurrent checks on the ports of the config word block
`default_nettype none
module sbcp_config_regs_chk (
    input wire logic        mclk_in,
    input wire logic        reset_in,
    input wire logic [15:0] reg_addr_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic [2:0]  reg_resp_out,
    input wire logic        reg_done_out,
    input wire logic        power_stage_enabled_in,
    input wire logic        power_on_event_in,
    input wire logic [15:0] pulse_reference_out,
    input wire logic [3:0]  operating_mode_out,
    input wire logic        io_preset_load_out,
    input wire logic        velocity_limit_active_out,
    input wire logic        torque_limit_active_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking dcb @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    chk_done_follows:
    assert property ((reg_wr_in || reg_rd_in) |=> reg_done_out)
        else $error("done missing after strobe");
    chk_pulse_locked:
    assert property (reg_wr_in && reg_addr_in == 16'h0200
        && power_stage_enabled_in |=> reg_resp_out == 3'h2
        ##1 $stable(pulse_reference_out)) else $error("pulse word not locked");
    chk_pulse_range:
    assert property (reg_wr_in && reg_addr_in == 16'h0200
        && reg_wdata_in[15:12] > 4'h1 |=> reg_resp_out == 3'h2)
        else $error("pulse word range");
    chk_mode_range:
    assert property (reg_wr_in && reg_addr_in == 16'h0202
        && reg_wdata_in[3:0] > 4'ha |=> reg_resp_out == 3'h2)
        else $error("mode word range");
    chk_mode_held:
    assert property ($changed(operating_mode_out)
        |-> $past(power_on_event_in, 2)) else $error("mode changed early");
    chk_preset_cause:
    assert property (io_preset_load_out |-> $past(power_on_event_in))
        else $error("preset pulse without power-on");
    chk_limits_on:
    assert property (reg_wr_in && reg_addr_in == 16'h0204
        && reg_wdata_in == 16'h0011 |=> ##1 velocity_limit_active_out
        && torque_limit_active_out) else $error("limits not enabled");
    chk_unmapped_resp:
    assert property ((reg_wr_in || reg_rd_in) && reg_addr_in > 16'h0204
        |=> reg_resp_out == 3'h4) else $error("unmapped not flagged");
endmodule
bind sbcp_config_regs sbcp_config_regs_chk u_chk (.*);
`default_nettype wire

// ---- sim/sbcp_bus_master.sv ----
// fieldbus master model for single-word register accesses
`default_nettype none
module sbcp_bus_master (
    input  wire logic        mclk_in,
    input  wire logic        done_in,
    input  wire logic [15:0] rdata_in,
    input  wire logic [2:0]  resp_in,
    output var logic  [15:0] addr_out,
    output var logic         wr_out,
    output var logic         rd_out,
    output var logic  [15:0] wdata_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {addr_out, wdata_out, wr_out, rd_out} = 34'h0;
    end
    // one 16-bit word per access, strobe high for a single cycle
    task automatic access(input logic w, input logic [15:0] a, d,
                          output logic [15:0] q, output logic [2:0] r);
        int n;
        @(negedge mclk_in);
        {addr_out, wdata_out, wr_out, rd_out} = {a, d, w, !w};
        @(negedge mclk_in);
        {wr_out, rd_out} = 2'h0;
        n = 0;
        while (done_in !== 1'b1 && n < 4) begin
            @(negedge mclk_in);
            n++;
        end
        q = rdata_in;
        // a missing answer comes back as no valid response code
        r = (done_in === 1'b1) ? resp_in : 3'h0;
        // released lines must not look like a held request
        {addr_out, wdata_out} = {~a, ~d};
    endtask
endmodule
`default_nettype wire

// ---- sim/servo_basic_config_params_tb.sv ----
// testbench for the servo basic config word block
`default_nettype none
module servo_basic_config_params_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk_in, reset_in, reg_wr_in, reg_rd_in, reg_done_out;
    logic [15:0] reg_addr_in, reg_wdata_in, reg_rdata_out, q;
    logic [2:0]  reg_resp_out, r;
    logic        power_stage_enabled_in, power_on_event_in;
    logic        velocity_limit_input_in, torque_limit_input_in;
    logic        velocity_select_bit0_in, velocity_select_bit1_in;
    logic        torque_select_bit0_in, torque_select_bit1_in;
    logic [31:0] velocity_value1_in, velocity_value2_in, velocity_value3_in;
    logic [31:0] velocity_analog_in, velocity_reference_out;
    logic [15:0] torque_value1_in, torque_value2_in, torque_value3_in;
    logic [15:0] torque_analog_in, torque_actual_in, torque_reference_out;
    logic [15:0] pulse_reference_out;
    logic [3:0]  operating_mode_out, direction_out;
    logic        io_preset_load_out, velocity_limit_active_out;
    logic        torque_limit_active_out, torque_limit_reached_out;
    logic [31:0] vexp [4] = '{32'h1388, 32'h2710, 32'h4e20, 32'h7530};
    logic [15:0] texp [4] = '{16'h0032, 16'h0064, 16'h00c8, 16'h012c};
    logic [15:0] tq [4] = '{16'h0063, 16'h0064, 16'hff9c, 16'hff9d};
    logic        tr [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    int          bad_count, n_compared;
    sbcp_config_regs u_dut (.*);
    sbcp_bus_master u_master (.mclk_in(mclk_in), .done_in(reg_done_out),
        .rdata_in(reg_rdata_out), .resp_in(reg_resp_out),
        .addr_out(reg_addr_in), .wr_out(reg_wr_in), .rd_out(reg_rd_in),
        .wdata_out(reg_wdata_in));
    task automatic check(input string s, input logic [31:0] v, e);
        n_compared++;
        if (v !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", s, e, v);
        end
    endtask
    task automatic wr(input logic [15:0] a, d, input logic [2:0] e);
        u_master.access(1'b1, a, d, q, r);
        check("write resp", {29'h0, r}, {29'h0, e});
    endtask
    task automatic rd(input logic [15:0] a, e);
        u_master.access(1'b0, a, 16'h0000, q, r);
        check("read answer", {31'h0, (r != 3'h0)}, 32'h1);
        check("read data", {16'h0, q}, {16'h0, e});
    endtask
    // mode word only takes effect on the power-on pulse
    task automatic power_on(input logic [31:0] ep, em);
        @(negedge mclk_in);
        power_on_event_in = 1'b1;
        @(negedge mclk_in);
        power_on_event_in = 1'b0;
        check("preset", {31'h0, io_preset_load_out}, ep);
        @(negedge mclk_in);
        check("mode", {28'h0, operating_mode_out}, em);
    endtask
    task automatic tally_and_finish;
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        mclk_in = 1'b0;
        forever #20 mclk_in = ~mclk_in;
    end
    initial begin
        #100000;
        bad_count++;
        tally_and_finish;
    end
    initial begin
        {reset_in, power_stage_enabled_in, power_on_event_in} = 3'h6;
        {velocity_limit_input_in, torque_limit_input_in} = 2'h0;
        {velocity_select_bit1_in, velocity_select_bit0_in} = 2'h0;
        {torque_select_bit1_in, torque_select_bit0_in} = 2'h0;
        {velocity_analog_in, velocity_value1_in} = {vexp[0], vexp[1]};
        {velocity_value2_in, velocity_value3_in} = {vexp[2], vexp[3]};
        {torque_analog_in, torque_value1_in} = {texp[0], texp[1]};
        {torque_value2_in, torque_value3_in} = {texp[2], texp[3]};
        torque_actual_in = 16'h0000;
        repeat (2) @(negedge mclk_in);
        reset_in = 1'b0;
        rd(16'h0200, 16'h0002);
        rd(16'h0202, 16'h0000);
        rd(16'h0204, 16'h0000);
        wr(16'h0200, 16'h1132, 3'h2);
        rd(16'h0200, 16'h0002);
        power_stage_enabled_in = 1'b0;
        wr(16'h0200, 16'h1132, 3'h1);
        wr(16'h0200, 16'h2000, 3'h2);
        rd(16'h0200, 16'h1132);
        check("pulse", {16'h0, pulse_reference_out}, 32'h1132);
        wr(16'h0202, 16'h110b, 3'h2);
        wr(16'h0202, 16'h1103, 3'h1);
        repeat (3) @(negedge mclk_in);
        check("mode", {28'h0, operating_mode_out}, 32'h0);
        power_on(32'h1, 32'h3);
        check("dir", {28'h0, direction_out}, 32'h1);
        wr(16'h0202, 16'h0105, 3'h1);
        power_on(32'h0, 32'h5);
        wr(16'h0204, 16'h0020, 3'h2);
        wr(16'h0204, 16'h0011, 3'h1);
        @(negedge mclk_in);
        check("vlim", {31'h0, velocity_limit_active_out}, 32'h1);
        check("tlim", {31'h0, torque_limit_active_out}, 32'h1);
        wr(16'h0204, 16'h0000, 3'h1);
        @(negedge mclk_in);
        check("vlim", {31'h0, velocity_limit_active_out}, 32'h0);
        {velocity_limit_input_in, torque_limit_input_in} = 2'h3;
        repeat (4) @(negedge mclk_in);
        check("vpin", {31'h0, velocity_limit_active_out}, 32'h1);
        check("tpin", {31'h0, torque_limit_active_out}, 32'h1);
        for (int c = 0; c < 4; c++) begin
            {velocity_select_bit1_in, velocity_select_bit0_in} = 2'(c);
            {torque_select_bit1_in, torque_select_bit0_in} = 2'(c);
            repeat (4) @(negedge mclk_in);
            check("vref", velocity_reference_out, vexp[c]);
            check("tref", 32'(torque_reference_out), 32'(texp[c]));
        end
        {torque_select_bit1_in, torque_select_bit0_in} = 2'h1;
        repeat (4) @(negedge mclk_in);
        foreach (tq[i]) begin
            torque_actual_in = tq[i];
            repeat (2) @(negedge mclk_in);
            check("reach", 32'(torque_limit_reached_out), 32'(tr[i]));
        end
        rd(16'h0206, 16'h0000);
        check("resp", {29'h0, r}, 32'h4);
        tally_and_finish;
    end
endmodule
`default_nettype wire
